// *** src/capture_cfg_regs.vh ***
`ifndef CAPTURE_CFG_REGS_VH
`define CAPTURE_CFG_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define CFG_OFFSET 12'h000
`define ENABLE_OFFSET 12'h004
`define SLAVE_OFFSET 12'h008
`define STATUS_OFFSET 12'h00C

// ****************************************
// reset values
// ****************************************
`define CFG_RESET 16'h0000
`define ENABLE_RESET 2'h0
`define SLAVE_RESET 3'h0

// ****************************************
// configuration register fields
// ****************************************
`define CH1_DIR_LSB 0
`define CH1_DIV_LSB 2
`define CH1_FILT_LSB 4
`define CH2_DIR_LSB 8
`define CH2_DIV_LSB 10
`define CH2_FILT_LSB 12
`define CH_FIELD_STRIDE 8
`define CFG_USED_BITS 16

// ****************************************
// enable and slave-mode fields
// ****************************************
`define CH1_EN_BIT 0
`define CH2_EN_BIT 1
`define TRIG_SEL_LSB 0
`define TRIG_SEL_WIDTH 3
`define TRIG_SEL_INTERNAL_LIMIT 3'h3

// ****************************************
// status register fields
// ****************************************
`define STATUS_PIN_LSB 0
`define STATUS_CAPT_LSB 2
`define STATUS_CH1_CNT_LSB 4
`define STATUS_CH2_CNT_LSB 8

// ****************************************
// direction codes
// ****************************************
`define DIR_OUTPUT 2'h0
`define DIR_OWN_PIN 2'h1
`define DIR_NEIGHBOUR_PIN 2'h2
`define DIR_TRIGGER 2'h3

// ****************************************
// filter and prescaler timing
// ****************************************
`define FILT_NONE 4'h0
`define FILT_DIV_WIDTH 5
`define FILT_CNT_WIDTH 4
`define PSC_CNT_WIDTH 3

`endif

// *** src/input_filter.v ***
`timescale 1ns/10ps
`default_nettype none
`include "capture_cfg_regs.vh"

module input_filter (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // sample and filter setting
  input wire sample_in,
  input wire [3:0] filter_sel,
  // filtered level
  output reg level_q
);

  // ****************************************
  // filter code decoding
  // ****************************************
  // log2 of the divider from the base clock to the sample rate
  function [2:0] div_log2;
    input [3:0] code;
    begin
      case (code)
        4'h1, 4'h2, 4'h3: div_log2 = 3'h0;
        4'h4, 4'h5: div_log2 = 3'h1;
        4'h6, 4'h7: div_log2 = 3'h2;
        4'h8, 4'h9: div_log2 = 3'h3;
        4'hA, 4'hB, 4'hC: div_log2 = 3'h4;
        4'hD, 4'hE, 4'hF: div_log2 = 3'h5;
        default: div_log2 = 3'h0;
      endcase
    end
  endfunction

  // consecutive agreeing samples needed
  function [3:0] need_count;
    input [3:0] code;
    begin
      case (code)
        4'h1: need_count = 4'h2;
        4'h2: need_count = 4'h4;
        4'h4, 4'h6, 4'h8, 4'hB, 4'hE: need_count = 4'h6;
        4'hA, 4'hD: need_count = 4'h5;
        4'h3, 4'h5, 4'h7, 4'h9, 4'hC, 4'hF: need_count = 4'h8;
        default: need_count = 4'h2;
      endcase
    end
  endfunction

  reg [`FILT_DIV_WIDTH-1:0] div_q;
  reg [`FILT_CNT_WIDTH-1:0] match_q;
  wire [`FILT_DIV_WIDTH-1:0] div_last;
  wire [`FILT_CNT_WIDTH-1:0] match_next;
  wire tick;

  // divide by 32 wraps the 5-bit shift to zero, minus one gives 31
  assign div_last = (5'h01 << div_log2(filter_sel)) - 5'h01; // R13
  assign tick = (div_q >= div_last);
  assign match_next = match_q + 4'h1;

  // ****************************************
  // sample counter
  // ****************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_q <= 1'b0;
      div_q <= 5'h00;
      match_q <= 4'h0;
    end
    else if (filter_sel == `FILT_NONE)
    begin
      // no filter: follow the input at the base clock
      level_q <= sample_in; // R9
      div_q <= 5'h00;
      match_q <= 4'h0;
    end
    else
    begin
      div_q <= tick ? 5'h00 : div_q + 5'h01; // R10
      if (tick)
      begin
        if (sample_in == level_q)
          match_q <= 4'h0;
        else if (match_next >= need_count(filter_sel))
        begin
          level_q <= sample_in; // R8
          match_q <= 4'h0;
        end
        else
          match_q <= match_next;
      end
    end
  end

endmodule
`default_nettype wire

// *** src/capture_input_channel_config.v ***
// Behaviour
// R1: ch1 direction: output, own, neighbour, trigger.
// R2: trigger source only if internal trigger selected.
// R3: ch1 direction writable only while disabled.
// R4: ch2 direction: output, own, neighbour, trigger.
// R5: ch2 direction writable only while disabled.
// R6: ch1 prescaler captures every 1,2,4,8 events.
// R7: ch1 prescaler cleared while channel disabled.
// R8: filter needs N consecutive agreeing samples.
// R9: code 0000 means no filter, base rate.
// R10: codes 1110/1111 divide 32, need 6/8.
// R11: software keeps upper sixteen bits at zero.
// R12: ch2 filter and prescaler mirror channel 1.
// R13: other filter codes use fixed divider, count.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "capture_cfg_regs.vh"

module capture_input_channel_config (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // timer pins and internal trigger
  input wire timer_pin_in_a,
  input wire timer_pin_in_b,
  input wire internal_trigger_capture_src,
  // channel results
  output reg ch1_capture_input,
  output reg ch2_capture_input,
  output reg ch1_capture_event,
  output reg ch2_capture_event,
  output reg ch1_is_input,
  output reg ch2_is_input
);

  // ****************************************
  // decoding helpers
  // ****************************************
  // last count value of the capture prescaler
  function [`PSC_CNT_WIDTH-1:0] psc_last;
    input [1:0] code;
    begin
      case (code)
        2'h0: psc_last = 3'h0;
        2'h1: psc_last = 3'h1;
        2'h2: psc_last = 3'h3;
        2'h3: psc_last = 3'h7;
        default: psc_last = 3'h0;
      endcase
    end
  endfunction

  function addr_hit;
    input [11:0] addr;
    input [11:0] offset;
    begin
      addr_hit = (addr[11:2] == offset[11:2]);
    end
  endfunction

  // ****************************************
  // registers
  // ****************************************
  reg [`CFG_USED_BITS-1:0] cfg_q;
  reg [`CFG_USED_BITS-1:0] cfg_d;
  reg [1:0] enable_q;
  reg [`TRIG_SEL_WIDTH-1:0] trig_sel_q;
  reg [31:0] rdata_d;

  wire setup_phase;
  wire access_wr;
  wire mapped;
  wire trig_internal;

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg [1:0] pin_meta_q;
  reg [1:0] pin_sync_q;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_q <= 2'h0;
      pin_sync_q <= 2'h0;
    end
    else
    begin
      pin_meta_q <= {timer_pin_in_b, timer_pin_in_a};
      pin_sync_q <= pin_meta_q;
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  // zero wait states: data is prepared during the setup cycle
  assign pready = 1'b1;
  assign setup_phase = psel & ~penable;
  assign access_wr = psel & penable & pwrite;
  assign mapped = addr_hit(paddr, `CFG_OFFSET) |
                  addr_hit(paddr, `ENABLE_OFFSET) |
                  addr_hit(paddr, `SLAVE_OFFSET) |
                  addr_hit(paddr, `STATUS_OFFSET);
  assign pslverr = psel & penable & ~mapped;

  // direction fields freeze while their channel runs
  always @*
  begin
    cfg_d = cfg_q;
    if (access_wr && addr_hit(paddr, `CFG_OFFSET))
    begin
      // upper half is reserved and never stored
      cfg_d = pwdata[`CFG_USED_BITS-1:0]; // R11
      if (enable_q[`CH1_EN_BIT])
        cfg_d[`CH1_DIR_LSB +: 2] = cfg_q[`CH1_DIR_LSB +: 2]; // R3
      if (enable_q[`CH2_EN_BIT])
        cfg_d[`CH2_DIR_LSB +: 2] = cfg_q[`CH2_DIR_LSB +: 2]; // R5
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q <= `CFG_RESET;
      enable_q <= `ENABLE_RESET;
      trig_sel_q <= `SLAVE_RESET;
    end
    else
    begin
      cfg_q <= cfg_d;
      if (access_wr && addr_hit(paddr, `ENABLE_OFFSET))
        enable_q <= pwdata[1:0];
      if (access_wr && addr_hit(paddr, `SLAVE_OFFSET))
        trig_sel_q <= pwdata[`TRIG_SEL_LSB +: `TRIG_SEL_WIDTH];
    end
  end

  // ****************************************
  // channel datapath
  // ****************************************
  wire [1:0] filt_level;
  wire [1:0] sel_level;
  wire [1:0] sel_valid;
  wire [1:0] capt_pulse;
  wire [`PSC_CNT_WIDTH*2-1:0] psc_count;

  // trigger selections at or below the limit are internal inputs
  assign trig_internal = (trig_sel_q <= `TRIG_SEL_INTERNAL_LIMIT); // R2

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : chan
      wire [1:0] dir;
      wire [1:0] div_code;
      wire [3:0] filt_code;
      wire enabled;
      reg level;
      reg valid;
      reg prev_q;
      reg [`PSC_CNT_WIDTH-1:0] cnt_q;
      wire edge_seen;

      assign dir = cfg_q[ch*`CH_FIELD_STRIDE + `CH1_DIR_LSB +: 2];
      assign div_code = cfg_q[ch*`CH_FIELD_STRIDE + `CH1_DIV_LSB +: 2];
      assign filt_code = cfg_q[ch*`CH_FIELD_STRIDE + `CH1_FILT_LSB +: 4];
      assign enabled = enable_q[ch];

      input_filter u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .sample_in(pin_sync_q[ch]),
        .filter_sel(filt_code),
        .level_q(filt_level[ch])
      ); // R12

      // source mux; the neighbour of channel 1 is channel 2 and back
      always @*
      begin
        level = 1'b0;
        valid = 1'b0;
        case (dir)
          `DIR_OUTPUT:
          begin
            level = 1'b0;
            valid = 1'b0;
          end
          `DIR_OWN_PIN:
          begin
            level = filt_level[ch];
            valid = 1'b1;
          end
          `DIR_NEIGHBOUR_PIN:
          begin
            level = filt_level[1-ch];
            valid = 1'b1;
          end
          `DIR_TRIGGER:
          begin
            level = internal_trigger_capture_src & trig_internal; // R2
            valid = trig_internal;
          end
          default:
          begin
            level = 1'b0;
            valid = 1'b0;
          end
        endcase
      end

      assign sel_level[ch] = level;
      assign sel_valid[ch] = valid;

      // a direction change can look like an edge; the channel is off then
      assign edge_seen = valid & enabled & level & ~prev_q;

      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          prev_q <= 1'b0;
          cnt_q <= 3'h0;
        end
        else
        begin
          prev_q <= level;
          if (!enabled)
            cnt_q <= 3'h0; // R7
          else if (edge_seen)
            cnt_q <= (cnt_q >= psc_last(div_code)) ? 3'h0 : cnt_q + 3'h1;
        end
      end

      assign capt_pulse[ch] = edge_seen & (cnt_q >= psc_last(div_code)); // R6
      assign psc_count[ch*`PSC_CNT_WIDTH +: `PSC_CNT_WIDTH] = cnt_q;
    end
  endgenerate

  // ****************************************
  // registered outputs
  // ****************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ch1_capture_input <= 1'b0;
      ch2_capture_input <= 1'b0;
      ch1_capture_event <= 1'b0;
      ch2_capture_event <= 1'b0;
      ch1_is_input <= 1'b0;
      ch2_is_input <= 1'b0;
    end
    else
    begin
      ch1_capture_input <= sel_level[0]; // R1
      ch2_capture_input <= sel_level[1]; // R4
      ch1_capture_event <= capt_pulse[0]; // R6
      ch2_capture_event <= capt_pulse[1]; // R12
      ch1_is_input <= (cfg_q[`CH1_DIR_LSB +: 2] != `DIR_OUTPUT); // R1
      ch2_is_input <= (cfg_q[`CH2_DIR_LSB +: 2] != `DIR_OUTPUT); // R4
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always @*
  begin
    rdata_d = 32'h00000000;
    if (addr_hit(paddr, `CFG_OFFSET))
      rdata_d[`CFG_USED_BITS-1:0] = cfg_q;
    else if (addr_hit(paddr, `ENABLE_OFFSET))
      rdata_d[1:0] = enable_q;
    else if (addr_hit(paddr, `SLAVE_OFFSET))
      rdata_d[`TRIG_SEL_LSB +: `TRIG_SEL_WIDTH] = trig_sel_q;
    else if (addr_hit(paddr, `STATUS_OFFSET))
    begin
      rdata_d[`STATUS_PIN_LSB +: 2] = filt_level;
      rdata_d[`STATUS_CAPT_LSB +: 2] = sel_level & sel_valid;
      rdata_d[`STATUS_CH1_CNT_LSB +: 3] = psc_count[2:0];
      rdata_d[`STATUS_CH2_CNT_LSB +: 3] = psc_count[5:3];
    end
  end

  // status is captured at the setup cycle and held for the access
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup_phase && !pwrite)
      prdata <= rdata_d;
  end

endmodule
`default_nettype wire

// *** tb/pin_source.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// far side: timer pins and trigger
// ****************************************
module pin_source (
  // clock
  input wire logic pclk,
  // wanted levels
  input wire logic want_a,
  input wire logic want_b,
  input wire logic want_t,
  // driven lines
  output logic pin_a,
  output logic pin_b,
  output logic trg
);
  // pins move just after an edge, like a driver on the same clock
  initial
  begin
    pin_a = 1'b0;
    pin_b = 1'b0;
    trg = 1'b0;
  end
  always @(posedge pclk)
  begin
    pin_a <= want_a;
    pin_b <= want_b;
    trg <= want_t;
  end
endmodule
`default_nettype wire

// *** tb/capture_cfg_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module capture_cfg_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // channel results
  input wire logic ch1_capture_event,
  input wire logic ch2_capture_event,
  input wire logic ch1_is_input,
  input wire logic ch2_is_input
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property
    (psel && penable && paddr[11:2] > 3 |-> pslverr)
    else $error("no error on unmapped access");
  a_err_mapped: assert property
    (psel && penable && paddr[11:2] < 4 |-> !pslverr)
    else $error("error on mapped access");
  a_rdata_hold: assert property
    (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  a_ev1_pulse: assert property (ch1_capture_event |=> !ch1_capture_event)
    else $error("ch1 event longer than one cycle");
  a_ev2_pulse: assert property
    (ch2_capture_event |=> !ch2_capture_event)
    else $error("ch2 event longer than one cycle");
  a_ev1_dir: assert property (ch1_capture_event |-> ch1_is_input)
    else $error("ch1 event while output");
  a_ev2_dir: assert property (ch2_capture_event |-> ch2_is_input)
    else $error("ch2 event while output");
endmodule
bind capture_input_channel_config capture_cfg_checker chk_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .prdata,
  .ch1_capture_event, .ch2_capture_event, .ch1_is_input, .ch2_is_input);
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "capture_cfg_regs.vh"
module tb_top;
  localparam logic [31:0] all_bits = 32'hFFFFFFFF;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, want_a = 1'b0, want_b = 1'b0, want_t = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, v;
  logic [31:0] eq[$], mq[$];
  logic [7:0] ev1 = 8'h00;
  logic [7:0] ev2 = 8'h00;
  int bad_count = 0, compares = 0, cyc = 0;
  wire pready, pslverr, pin_a, pin_b, trg, c1, c2, e1, e2, i1, i2;
  wire [31:0] prdata;
  pin_source far_i (.pclk(pclk), .want_a(want_a), .want_b(want_b),
    .want_t(want_t), .pin_a(pin_a), .pin_b(pin_b), .trg(trg));
  capture_input_channel_config uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .timer_pin_in_a(pin_a), .timer_pin_in_b(pin_b),
    .internal_trigger_capture_src(trg), .ch1_capture_input(c1),
    .ch2_capture_input(c2), .ch1_capture_event(e1), .ch2_capture_event(e2),
    .ch1_is_input(i1), .ch2_is_input(i2));
  initial
  begin
    forever #50 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] g,
    input logic [31:0] m);
    compares++;
    if ((g & m) !== (e & m))
    begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic results;
    $display("bad_count %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
    input logic [31:0] m);
    eq.push_back(e);
    mq.push_back(m);
    apb(1'b0, a, 32'h00000000);
  endtask
  // ****************************************
  // watcher: read data against notes
  // ****************************************
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (psel && penable && pready && !pwrite && eq.size() > 0)
      chk(eq.pop_front(), prdata, mq.pop_front());
    if (e1 === 1'b1)
      ev1 <= ev1 + 8'h01;
    if (e2 === 1'b1)
      ev2 <= ev2 + 8'h01;
    // the limit lies far past the normal end of the run, so it only ends a hung run
    if (cyc == 20000)
    begin
      bad_count++;
      results;
    end
  end
  initial
  begin
    void'($urandom(5348));
    waitc(10);
    presetn <= 1'b1;
    rd(`CFG_OFFSET, 32'h00000000, all_bits);
    rd(`ENABLE_OFFSET, 32'h00000000, all_bits);
    rd(`SLAVE_OFFSET, 32'h00000000, all_bits);
    for (int d = 0; d < 4; d++)
    begin
      // upper half left at zero by software
      v = ($urandom & 32'h0000F0F0) | d | (d << 8);
      apb(1'b1, `CFG_OFFSET, v);
      rd(`CFG_OFFSET, v, all_bits);
      chk({31'h0, d != 0}, {31'h0, i1}, all_bits);
      chk({31'h0, d != 0}, {31'h0, i2}, all_bits);
    end
    apb(1'b1, `CFG_OFFSET, 32'h00000101);
    apb(1'b1, `ENABLE_OFFSET, 32'h00000003);
    apb(1'b1, `CFG_OFFSET, 32'h00000A0E);
    rd(`CFG_OFFSET, 32'h0000090D, all_bits);
    apb(1'b1, `ENABLE_OFFSET, 32'h00000001);
    apb(1'b1, `CFG_OFFSET, 32'h00000A0E);
    rd(`CFG_OFFSET, 32'h00000A0D, all_bits);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, `ENABLE_OFFSET, 32'h00000000);
      apb(1'b1, `CFG_OFFSET, (k << 2) | 1);
      apb(1'b1, `ENABLE_OFFSET, 32'h00000001);
      ev1 <= 8'h00;
      repeat (8)
      begin
        want_a <= 1'b1;
        waitc(4);
        want_a <= 1'b0;
        waitc(4);
      end
      waitc(8);
      chk(32'h8 >> k, {24'h0, ev1}, all_bits);
      // one more edge leaves the divider part way, except without division
      want_a <= 1'b1;
      waitc(4);
      want_a <= 1'b0;
      waitc(8);
      rd(`STATUS_OFFSET, (k != 0) ? 32'h10 : 32'h0, 32'h00000070);
      apb(1'b1, `ENABLE_OFFSET, 32'h00000000);
      rd(`STATUS_OFFSET, 32'h00000000, 32'h00000070);
    end
    apb(1'b1, `CFG_OFFSET, 32'h0000F1F1);
    want_a <= 1'b1;
    want_b <= 1'b1;
    // eight samples at one in thirty-two settle just after cycle 256
    waitc(250);
    chk(32'h0, {30'h0, c2, c1}, all_bits);
    waitc(20);
    chk(32'h3, {30'h0, c2, c1}, all_bits);
    apb(1'b1, `CFG_OFFSET, 32'h00000003);
    apb(1'b1, `SLAVE_OFFSET, 32'h00000004);
    want_t <= 1'b1;
    waitc(5);
    chk(32'h0, {31'h0, c1}, all_bits);
    apb(1'b1, `SLAVE_OFFSET, 32'h00000000);
    waitc(5);
    chk(32'h1, {31'h0, c1}, all_bits);
    // crossed pins: a pulses four times, b only twice
    want_a <= 1'b0;
    want_b <= 1'b0;
    apb(1'b1, `CFG_OFFSET, 32'h00000602);
    apb(1'b1, `ENABLE_OFFSET, 32'h00000003);
    ev1 <= 8'h00;
    ev2 <= 8'h00;
    for (int p = 0; p < 4; p++)
    begin
      want_a <= 1'b1;
      want_b <= (p % 2 == 0);
      waitc(4);
      want_a <= 1'b0;
      want_b <= 1'b0;
      waitc(4);
    end
    waitc(8);
    chk(32'h2, {24'h0, ev1}, all_bits);
    chk(32'h2, {24'h0, ev2}, all_bits);
    rd(12'h010, 32'h00000000, all_bits);
    waitc(2);
    results;
  end
endmodule
`default_nettype wire
